// ===== logic/cpu_regmem_core.sv
// Execution core for the register/memory, read-modify-write and multiply instructions.
// Assumes a memory whose read data follow mem_req.addr within the same cycle, and software
// that reaches the control registers over the plain register port.
//
// Behaviour
// - Recognise the instruction classes, trap the rest.
// - Multiply index and accumulator as unsigned.
// - Product high to index, low to accumulator.
// - Multiply is inherent opcode 42, eleven cycles.
// - Opcode picks accumulator or index operand.
// - Memory operand from six addressing modes.
// - Jumps load program counter with address.
// - Read-modify-write returns result to source.
// - Test updates flags without writing back.
// - Add-with-carry adds operand and carry.
// - Subtract-with-borrow removes operand and borrow.
// - Exclusive-or merges operand into accumulator.
// - Accumulator compare sets flags only.
// - Index compare sets flags only.
// - Bit test ANDs for flags only.
//
// Strobed register access and the register offsets were decided locally.
`include "cpu_core_defs.svh"

module cpu_regmem_core (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire cpu_core_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output cpu_core_pkg::mem_req_t mem_req,
	input wire logic [7:0] mem_rdata
);
	import cpu_core_pkg::*;

	// Addressing mode from the high nibble of the opcode.
	function automatic mode_t op_mode(input logic [7:0] op);
		case (op[7:4])
			`NIB_IMM: op_mode = am_immediate;
			`NIB_DIR, `NIB_RMW_DIR: op_mode = am_direct;
			`NIB_EXT: op_mode = am_extended;
			`NIB_IX16: op_mode = am_indexed16;
			`NIB_IX8, `NIB_RMW_IX8: op_mode = am_indexed8;
			`NIB_IX0, `NIB_RMW_IX0: op_mode = am_indexed0;
			`NIB_RMW_ACC, `NIB_RMW_IDX: op_mode = am_inherent;
			default: op_mode = am_none;
		endcase
	endfunction

	// Instruction class; branch, bit and control opcodes fall out as illegal here.
	function automatic kind_t op_kind(input logic [7:0] op);
		mode_t m;
		rm_fn_t f;
		m = op_mode(op);
		f = rm_fn_t'(op[3:0]);
		if (op == `OP_PRODUCT) begin
			op_kind = k_product;
		end else if (m == am_none) begin
			op_kind = k_illegal;
		end else if (op[7]) begin
			case (f)
				fn_store_acc, fn_store_index: op_kind = (m == am_immediate) ? k_illegal : k_store;
				fn_jump: op_kind = (m == am_immediate) ? k_illegal : k_jump;
				fn_call: op_kind = (m == am_immediate) ? k_illegal : k_call;
				default: op_kind = k_alu;
			endcase
		end else if (rmw_fn_t'(op[3:0]) inside {rmw_negate, rmw_complement, rmw_shift_right,
				rmw_rotate_right, rmw_arith_right, rmw_shift_left, rmw_rotate_left,
				rmw_decrement, rmw_increment, rmw_test, rmw_clear}) begin
			op_kind = (m == am_inherent) ? k_rmw_reg : k_rmw_mem;
		end else begin
			op_kind = k_illegal;
		end
	endfunction

	// Total core cycles of an instruction, counted from its opcode fetch.
	function automatic logic [3:0] op_cycles(input logic [7:0] op);
		logic [3:0] n;
		kind_t k;
		k = op_kind(op);
		case (op_mode(op))
			am_immediate: n = `CYC_IMM;
			am_direct: n = op[7] ? `CYC_DIR : `CYC_RMW_DIR;
			am_extended: n = `CYC_EXT;
			am_indexed16: n = `CYC_IX16;
			am_indexed8: n = op[7] ? `CYC_IX8 : `CYC_RMW_IX8;
			am_indexed0: n = op[7] ? `CYC_IX0 : `CYC_RMW_IX0;
			am_inherent: n = (op == `OP_PRODUCT) ? `CYC_PRODUCT : `CYC_RMW_REG;
			default: n = `CYC_RMW_REG;
		endcase
		if (k == k_store) begin
			n = n + `CYC_STORE_ADD;
		end else if (k == k_jump) begin
			n = n - `CYC_JUMP_SUB;
		end else if (k == k_call) begin
			n = n + `CYC_CALL_ADD;
		end else if (k == k_rmw_mem && rmw_fn_t'(op[3:0]) == rmw_test) begin
			n = n - `CYC_TEST_SUB;
		end
		op_cycles = n;
	endfunction

	// Register/memory arithmetic; compares and bit test keep their result out of registers.
	function automatic result_t alu_exec(input logic [3:0] fn, input logic [7:0] a,
			input logic [7:0] x, input logic [7:0] m, input logic cin);
		logic [8:0] wide;
		logic [4:0] half;
		logic ci;
		result_t r;
		r = '0;
		half = 5'h00;
		ci = (rm_fn_t'(fn) inside {fn_add_carry, fn_sub_borrow}) ? cin : 1'b0;
		case (rm_fn_t'(fn))
			fn_subtract, fn_compare_acc, fn_sub_borrow: wide = {1'b0, a} - {1'b0, m} - {8'h00, ci};
			fn_compare_index: wide = {1'b0, x} - {1'b0, m};
			fn_add, fn_add_carry: begin
				wide = {1'b0, a} + {1'b0, m} + {8'h00, ci};
				half = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, ci};
			end
			fn_and_acc, fn_bit_test: wide = {1'b0, a & m};
			fn_or_acc: wide = {1'b0, a | m};
			fn_xor_acc: wide = {1'b0, a ^ m};
			fn_load_acc, fn_load_index: wide = {1'b0, m};
			default: wide = {1'b0, a};
		endcase
		r.value = wide[7:0];
		r.n = wide[7];
		r.z = (wide[7:0] == 8'h00);
		r.c = wide[8];
		r.h = half[4];
		r.nz_en = 1'b1;
		r.c_en = rm_fn_t'(fn) inside {fn_subtract, fn_compare_acc, fn_sub_borrow,
			fn_compare_index, fn_add, fn_add_carry};
		r.h_en = rm_fn_t'(fn) inside {fn_add, fn_add_carry};
		r.write = rm_fn_t'(fn) inside {fn_subtract, fn_sub_borrow, fn_and_acc, fn_xor_acc,
			fn_add_carry, fn_or_acc, fn_add, fn_load_acc};
		r.write_idx = (rm_fn_t'(fn) == fn_load_index);
		alu_exec = r;
	endfunction

	// Read-modify-write operations on one byte.
	function automatic result_t rmw_exec(input logic [3:0] fn, input logic [7:0] v,
			input logic cin);
		result_t r;
		r = '0;
		r.write = 1'b1;
		r.nz_en = 1'b1;
		r.c_en = 1'b1;
		case (rmw_fn_t'(fn))
			rmw_negate: begin
				r.value = 8'h00 - v;
				r.c = (v != 8'h00);
			end
			rmw_complement: begin
				r.value = ~v;
				r.c = 1'b1;
			end
			rmw_shift_right: {r.value, r.c} = {1'b0, v};
			rmw_rotate_right: {r.value, r.c} = {cin, v};
			rmw_arith_right: {r.value, r.c} = {v[7], v};
			rmw_shift_left: {r.c, r.value} = {v, 1'b0};
			rmw_rotate_left: {r.c, r.value} = {v, cin};
			rmw_decrement: r.value = v - 8'h01;
			rmw_increment: r.value = v + 8'h01;
			rmw_clear: r.value = 8'h00;
			default: begin
				r.value = v;
				r.write = 1'b0;
			end
		endcase
		if (rmw_fn_t'(fn) inside {rmw_decrement, rmw_increment, rmw_clear, rmw_test}) begin
			r.c_en = 1'b0;
		end
		r.n = r.value[7];
		r.z = (r.value == 8'h00);
		rmw_exec = r;
	endfunction

	// Folds a result into the flags, touching only the enabled ones.
	function automatic flags_t apply_flags(input flags_t f, input result_t r);
		flags_t o;
		o = f;
		if (r.nz_en) begin
			o.n = r.n;
			o.z = r.z;
		end
		if (r.c_en) begin
			o.c = r.c;
		end
		if (r.h_en) begin
			o.h = r.h;
		end
		apply_flags = o;
	endfunction

	state_t state_reg, state_next;
	logic [15:0] pc_reg, pc_next, ea_reg, ea_next;
	logic [7:0] acc_reg, acc_next, x_reg, x_next, sp_reg, sp_next, op_reg, op_next;
	logic [7:0] b1_reg, b1_next;
	logic [3:0] cnt_reg;
	flags_t flags_reg, flags_next;
	logic run_reg, run_next, bad_reg, bad_next, bad_set;
	mem_req_t mem_next;
	logic addr_done;

	// Decode looks at the incoming byte during the opcode cycle, later at the held opcode.
	wire [7:0] op_w = (state_reg == st_opcode) ? mem_rdata : op_reg;
	wire mode_t mode_w = op_mode(op_w);
	wire kind_t kind_w = op_kind(op_w);
	wire [3:0] target_w = op_cycles(op_w);
	wire last_w = (cnt_reg == target_w - 4'h1);
	wire state_t fin_w = !last_w ? st_pad : (run_next ? st_opcode : st_idle);
	wire [15:0] product_w = {8'h00, x_reg} * {8'h00, acc_reg};
	wire result_t alu_w = alu_exec(op_w[3:0], acc_reg, x_reg, mem_rdata, flags_reg.c);
	wire use_idx_w = (op_w[7:4] == `NIB_RMW_IDX);
	wire [7:0] rmw_src_w = (kind_w == k_rmw_reg) ? (use_idx_w ? x_reg : acc_reg) : mem_rdata;
	wire result_t rmw_w = rmw_exec(op_w[3:0], rmw_src_w, flags_reg.c);
	wire [7:0] store_w = (rm_fn_t'(op_w[3:0]) == fn_store_index) ? x_reg : acc_reg;
	wire [15:0] ix_w = {8'h00, x_reg};
	wire sw_wr_idle = reg_req.wr && (state_reg == st_idle);

	// Effective address as the last address byte arrives.
	wire [15:0] ea_w = (state_reg == st_opcode) ?
		((mode_w == am_indexed0) ? ix_w : pc_reg + 16'h0001) :
		(state_reg == st_byte1) ?
		({`ZERO_PAGE, mem_rdata} + ((mode_w == am_indexed8) ? ix_w : 16'h0000)) :
		({b1_reg, mem_rdata} + ((mode_w == am_indexed16) ? ix_w : 16'h0000));

	// Sequencer: fetch, address bytes, operand access, write-back, then pad to length.
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		ea_next = ea_reg;
		acc_next = acc_reg;
		x_next = x_reg;
		sp_next = sp_reg;
		op_next = op_reg;
		b1_next = b1_reg;
		flags_next = flags_reg;
		mem_next = '0;
		mem_next.addr = mem_req.addr;
		addr_done = 1'b0;
		bad_set = 1'b0;
		run_next = run_reg;
		if (reg_req.wr && reg_req.addr == `REG_CTRL) begin
			run_next = reg_req.wdata[`CTRL_RUN_BIT];
		end
		case (state_reg)
			st_idle: begin
				if (run_next) begin
					state_next = st_opcode;
				end
			end
			st_opcode: begin
				op_next = mem_rdata;
				pc_next = pc_reg + 16'h0001;
				case (kind_w)
					k_illegal: begin
						bad_set = 1'b1;
						run_next = 1'b0;
						state_next = st_idle;
					end
					k_product: begin
						x_next = product_w[15:8];
						acc_next = product_w[7:0];
						flags_next.h = 1'b0;
						flags_next.c = 1'b0;
						state_next = fin_w;
					end
					k_rmw_reg: begin
						flags_next = apply_flags(flags_reg, rmw_w);
						if (rmw_w.write && use_idx_w) begin
							x_next = rmw_w.value;
						end else if (rmw_w.write) begin
							acc_next = rmw_w.value;
						end
						state_next = fin_w;
					end
					default: begin
						if (mode_w == am_immediate) begin
							pc_next = pc_reg + 16'h0002;
							addr_done = 1'b1;
						end else if (mode_w == am_indexed0) begin
							addr_done = 1'b1;
						end else begin
							state_next = st_byte1;
						end
					end
				endcase
			end
			st_byte1: begin
				pc_next = pc_reg + 16'h0001;
				b1_next = mem_rdata;
				if (mode_w inside {am_extended, am_indexed16}) begin
					state_next = st_byte2;
				end else begin
					addr_done = 1'b1;
				end
			end
			st_byte2: begin
				pc_next = pc_reg + 16'h0001;
				addr_done = 1'b1;
			end
			st_read: begin
				if (kind_w == k_alu) begin
					flags_next = apply_flags(flags_reg, alu_w);
					acc_next = alu_w.write ? alu_w.value : acc_reg;
					x_next = alu_w.write_idx ? alu_w.value : x_reg;
					state_next = fin_w;
				end else begin
					flags_next = apply_flags(flags_reg, rmw_w);
					if (rmw_w.write) begin
						mem_next.wdata = rmw_w.value;
						mem_next.we = 1'b1;
						state_next = st_write;
					end else begin
						state_next = fin_w;
					end
				end
			end
			st_push_lo: begin
				mem_next.addr = {`ZERO_PAGE, sp_reg - 8'h01};
				mem_next.wdata = pc_reg[15:8];
				mem_next.we = 1'b1;
				state_next = st_push_hi;
			end
			st_push_hi: begin
				sp_next = sp_reg - 8'h02;
				pc_next = ea_reg;
				state_next = fin_w;
			end
			st_write, st_pad: state_next = fin_w;
			default: state_next = st_idle;
		endcase
		if (addr_done) begin
			ea_next = ea_w;
			case (kind_w)
				k_store: begin
					mem_next.addr = ea_w;
					mem_next.wdata = store_w;
					mem_next.we = 1'b1;
					flags_next.n = store_w[7];
					flags_next.z = (store_w == 8'h00);
					state_next = st_write;
				end
				k_jump: begin
					pc_next = ea_w;
					state_next = fin_w;
				end
				k_call: begin
					mem_next.addr = {`ZERO_PAGE, sp_reg};
					mem_next.wdata = pc_next[7:0];
					mem_next.we = 1'b1;
					state_next = st_push_lo;
				end
				default: begin
					mem_next.addr = ea_w;
					mem_next.re = 1'b1;
					state_next = st_read;
				end
			endcase
		end
		if (sw_wr_idle) begin
			case (reg_req.addr)
				`REG_ACC: acc_next = reg_req.wdata;
				`REG_INDEX: x_next = reg_req.wdata;
				`REG_FLAGS: flags_next = flags_t'(reg_req.wdata[4:0]);
				`REG_PC_LO: pc_next = {pc_reg[15:8], reg_req.wdata};
				`REG_PC_HI: pc_next = {reg_req.wdata, pc_reg[7:0]};
				`REG_SP: sp_next = reg_req.wdata;
				default: ;
			endcase
		end
		// Address bytes come from the advanced program counter, not the held opcode address.
		if (state_next inside {st_byte1, st_byte2}) begin
			mem_next.addr = pc_next;
			mem_next.re = 1'b1;
		end
		if (state_next == st_opcode) begin
			mem_next.addr = pc_next;
			mem_next.re = 1'b1;
		end
		// A trap in the same cycle as a write-one-to-clear keeps the flag set.
		bad_next = (bad_reg & ~(reg_req.wr && reg_req.addr == `REG_STATUS &&
			reg_req.wdata[`STATUS_BADOP_BIT])) | bad_set;
	end

	// Register read selection; unmapped offsets read as zero.
	wire [7:0] rd_sel_w =
		(reg_req.addr == `REG_CTRL) ? {7'h00, run_reg} :
		(reg_req.addr == `REG_STATUS) ? {6'h00, bad_reg, state_reg != st_idle} :
		(reg_req.addr == `REG_ACC) ? acc_reg :
		(reg_req.addr == `REG_INDEX) ? x_reg :
		(reg_req.addr == `REG_FLAGS) ? {3'h0, flags_reg} :
		(reg_req.addr == `REG_PC_LO) ? pc_reg[7:0] :
		(reg_req.addr == `REG_PC_HI) ? pc_reg[15:8] :
		(reg_req.addr == `REG_SP) ? sp_reg :
		(reg_req.addr == `REG_OPCODE) ? op_reg : 8'h00;

	// Sequencer state and the memory request, registered so every output leaves a flip-flop.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= st_idle;
			cnt_reg <= 4'h0;
			mem_req <= '0;
			reg_rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= (state_next == st_opcode) ? 4'h0 : cnt_reg + 4'h1;
			mem_req <= mem_next;
			reg_rdata <= reg_req.rd ? rd_sel_w : 8'h00;
		end
	end

	// Programmer-visible registers.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_reg <= `PC_RESET;
			sp_reg <= `SP_RESET;
			flags_reg <= `FLAGS_RESET;
			{ea_reg, acc_reg, x_reg, op_reg, b1_reg, run_reg, bad_reg} <= '0;
		end else begin
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			flags_reg <= flags_next;
			{ea_reg, acc_reg, x_reg, op_reg, b1_reg, run_reg, bad_reg} <=
				{ea_next, acc_next, x_next, op_next, b1_next, run_next, bad_next};
		end
	end

	// Checks on the sequencer and the data path.
	sequence s_product_start;
		state_reg == st_opcode && mem_rdata == `OP_PRODUCT;
	endsequence
	sequence s_read_fn(logic [3:0] fn);
		state_reg == st_read && kind_w == k_alu && op_reg[3:0] == fn;
	endsequence

	property p_product_value;
		@(posedge core_clk) disable iff (!arst_n)
		s_product_start |=> {x_reg, acc_reg} == {8'h00, $past(x_reg)} * {8'h00, $past(acc_reg)};
	endproperty
	a_product_value: assert property (p_product_value) else $error("bad product");

	property p_product_flags;
		@(posedge core_clk) disable iff (!arst_n)
		s_product_start |=> !flags_reg.h && !flags_reg.c && flags_reg.n == $past(flags_reg.n)
			&& flags_reg.z == $past(flags_reg.z) && flags_reg.i == $past(flags_reg.i);
	endproperty
	a_product_flags: assert property (p_product_flags) else $error("product flags wrong");

	property p_product_length;
		@(posedge core_clk) disable iff (!arst_n)
		s_product_start ##1 run_reg |-> (state_reg == st_pad)[*8] ##1 (state_reg == st_pad)[*2]
			##1 state_reg inside {st_opcode, st_idle};
	endproperty
	a_product_length: assert property (p_product_length) else $error("product not 11 cycles");

	property p_add_carry_imm;
		@(posedge core_clk) disable iff (!arst_n)
		state_reg == st_opcode && mem_rdata == {`NIB_IMM, fn_add_carry} |=> state_reg == st_read
			##1 acc_reg == $past(acc_reg, 2) + $past(mem_rdata) + {7'h00, $past(flags_reg.c, 2)};
	endproperty
	a_add_carry_imm: assert property (p_add_carry_imm) else $error("add with carry wrong");

	property p_sub_borrow;
		@(posedge core_clk) disable iff (!arst_n)
		s_read_fn(fn_sub_borrow) |=>
			acc_reg == $past(acc_reg) - $past(mem_rdata) - {7'h00, $past(flags_reg.c)};
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("subtract with borrow wrong");

	property p_xor;
		@(posedge core_clk) disable iff (!arst_n)
		s_read_fn(fn_xor_acc) |=> acc_reg == ($past(acc_reg) ^ $past(mem_rdata));
	endproperty
	a_xor: assert property (p_xor) else $error("exclusive or wrong");

	property p_compare_acc;
		@(posedge core_clk) disable iff (!arst_n)
		s_read_fn(fn_compare_acc) |=> acc_reg == $past(acc_reg)
			&& flags_reg.z == ($past(acc_reg) == $past(mem_rdata));
	endproperty
	a_compare_acc: assert property (p_compare_acc) else $error("compare changed acc");

	property p_compare_index;
		@(posedge core_clk) disable iff (!arst_n)
		s_read_fn(fn_compare_index) |=> x_reg == $past(x_reg)
			&& flags_reg.c == ($past(x_reg) < $past(mem_rdata));
	endproperty
	a_compare_index: assert property (p_compare_index) else $error("index compare wrong");

	property p_bit_test;
		@(posedge core_clk) disable iff (!arst_n)
		s_read_fn(fn_bit_test) |=> acc_reg == $past(acc_reg)
			&& flags_reg.z == (($past(acc_reg) & $past(mem_rdata)) == 8'h00);
	endproperty
	a_bit_test: assert property (p_bit_test) else $error("bit test wrong");

	property p_rmw_same_place;
		@(posedge core_clk) disable iff (!arst_n)
		state_reg == st_read && kind_w == k_rmw_mem |=>
			mem_req.we == (rmw_fn_t'(op_reg[3:0]) != rmw_test)
			&& (!mem_req.we || mem_req.addr == $past(mem_req.addr));
	endproperty
	a_rmw_same_place: assert property (p_rmw_same_place) else $error("write-back misplaced");

	property p_jump_target;
		@(posedge core_clk) disable iff (!arst_n)
		state_reg == st_byte1 && op_reg == {`NIB_DIR, fn_jump} |=>
			pc_reg == {`ZERO_PAGE, $past(mem_rdata)};
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump target wrong");
endmodule

// ===== logic/cpu_core_defs.svh
// Constants for the register/memory execution core: register offsets, bit positions,
// reset values, opcode nibbles and instruction cycle counts.
// Assumes inclusion by the core and its bench only; it holds definitions and nothing else.
`ifndef CPU_CORE_DEFS_SVH
`define CPU_CORE_DEFS_SVH

// Software register offsets on the plain register port.
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_ACC 4'h2
`define REG_INDEX 4'h3
`define REG_FLAGS 4'h4
`define REG_PC_LO 4'h5
`define REG_PC_HI 4'h6
`define REG_SP 4'h7
`define REG_OPCODE 4'h8

// Bit positions inside the control and status registers.
`define CTRL_RUN_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_BADOP_BIT 1

// Reset values; the flags reset with only the interrupt mask set.
`define PC_RESET 16'h0000
`define SP_RESET 8'hFF
`define FLAGS_RESET 5'h08
`define ZERO_PAGE 8'h00

// The multiply opcode, then the opcode high nibbles that select the addressing mode.
`define OP_PRODUCT 8'h42
`define NIB_IMM 4'hA
`define NIB_DIR 4'hB
`define NIB_EXT 4'hC
`define NIB_IX16 4'hD
`define NIB_IX8 4'hE
`define NIB_IX0 4'hF
`define NIB_RMW_DIR 4'h3
`define NIB_RMW_ACC 4'h4
`define NIB_RMW_IDX 4'h5
`define NIB_RMW_IX8 4'h6
`define NIB_RMW_IX0 4'h7

// Core cycles per instruction, opcode fetch included.
`define CYC_IMM 4'h2
`define CYC_DIR 4'h3
`define CYC_EXT 4'h4
`define CYC_IX16 4'h5
`define CYC_IX8 4'h4
`define CYC_IX0 4'h3
`define CYC_PRODUCT 4'hB
`define CYC_RMW_REG 4'h3
`define CYC_RMW_DIR 4'h5
`define CYC_RMW_IX8 4'h6
`define CYC_RMW_IX0 4'h5
`define CYC_STORE_ADD 4'h1
`define CYC_JUMP_SUB 4'h1
`define CYC_CALL_ADD 4'h2
`define CYC_TEST_SUB 4'h1

`endif

// ===== logic/cpu_core_pkg.sv
// Types shared by the register/memory execution core and its bench.
// Assumes the constants header is compiled alongside it.
package cpu_core_pkg;
	typedef enum logic [3:0] {fn_subtract = 4'h0, fn_compare_acc = 4'h1, fn_sub_borrow = 4'h2,
		fn_compare_index = 4'h3, fn_and_acc = 4'h4, fn_bit_test = 4'h5, fn_load_acc = 4'h6,
		fn_store_acc = 4'h7, fn_xor_acc = 4'h8, fn_add_carry = 4'h9, fn_or_acc = 4'hA,
		fn_add = 4'hB, fn_jump = 4'hC, fn_call = 4'hD, fn_load_index = 4'hE,
		fn_store_index = 4'hF} rm_fn_t;
	typedef enum logic [3:0] {rmw_negate = 4'h0, rmw_complement = 4'h3, rmw_shift_right = 4'h4,
		rmw_rotate_right = 4'h6, rmw_arith_right = 4'h7, rmw_shift_left = 4'h8,
		rmw_rotate_left = 4'h9, rmw_decrement = 4'hA, rmw_increment = 4'hC, rmw_test = 4'hD,
		rmw_clear = 4'hF} rmw_fn_t;
	typedef enum logic [2:0] {am_inherent, am_immediate, am_direct, am_extended, am_indexed16,
		am_indexed8, am_indexed0, am_none} mode_t;
	typedef enum logic [2:0] {k_alu, k_store, k_jump, k_call, k_rmw_mem, k_rmw_reg, k_product,
		k_illegal} kind_t;
	typedef enum logic [3:0] {st_idle, st_opcode, st_byte1, st_byte2, st_read, st_write,
		st_push_lo, st_push_hi, st_pad} state_t;
	typedef struct packed {logic h; logic i; logic n; logic z; logic c;} flags_t;
	typedef struct packed {
		logic [7:0] value;
		logic h;
		logic n;
		logic z;
		logic c;
		logic h_en;
		logic c_en;
		logic nz_en;
		logic write;
		logic write_idx;
	} result_t;
	typedef struct packed {logic [3:0] addr; logic [7:0] wdata; logic wr; logic rd;} reg_req_t;
	typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic we; logic re;} mem_req_t;
endpackage

// ===== tb/mem_model.sv
// Program and data memory that stands on the far side of the execution core.
// Assumes a core that wants read data in the same cycle as the address.
module mem_model (
	input wire logic core_clk,
	input wire cpu_core_pkg::mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import cpu_core_pkg::*;
	logic [7:0] mem [0:65535];
	// A byte pattern everywhere, so that a stray fetch reads zero only where the low address byte is 5A.
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	// Reads are combinational because the core has no wait states.
	assign mem_rdata = mem[mem_req.addr];
	// One byte is stored at each edge that sees the write enable.
	always @(posedge core_clk) begin
		if (mem_req.we) begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the register/memory execution core.
// Assumes the memory model answers in the same cycle and the core is the only bus master.
`include "cpu_core_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cpu_core_pkg::*;
	typedef struct {logic [7:0] v; bit chk; string nm;} note_t;
	logic core_clk, arst_n, rd_seen;
	reg_req_t reg_req;
	mem_req_t mem_req;
	logic [7:0] reg_rdata, mem_rdata, status, a_v, x_v;
	logic [15:0] prod;
	logic [7:0] prog [24] = '{8'hA9, 8'h40, 8'hB9, 8'h80, 8'hC9, 8'h01, 8'h90, 8'hA2, 8'h05,
		8'hA8, 8'hFF, 8'h3C, 8'h81, 8'h3D, 8'h81, 8'hA1, 8'hF5, 8'hA3, 8'h10, 8'hA5, 8'h0A,
		8'hBC, 8'h30, 8'h22};
	logic [7:0] prog2 [10] = '{8'hBF, 8'h90, 8'hD6, 8'h01, 8'h00, 8'hF7, 8'hE6, 8'hF0, 8'hBD,
		8'h60};
	note_t note_q[$];
	note_t n;
	int fails = 0, samples_checked = 0, cyc = 0, t_op0 = 0, t_op1 = 0, writes = 0;
	cpu_regmem_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata));
	mem_model mem_u (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
	// Free-running core clock, 8 ns period.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Remember each read strobe, since its data stand only in the following cycle.
	always @(posedge core_clk) begin
		rd_seen <= reg_req.rd;
		cyc <= cyc + 1;
	end
	// Results are taken at the falling edge, where the one-cycle read data have settled.
	always @(negedge core_clk) begin
		if (rd_seen) begin
			n = note_q.pop_front();
			status = reg_rdata;
			if (n.chk) `CHK(n.nm, n.v, reg_rdata)
		end
		if (mem_req.re && mem_req.addr === 16'h0000) t_op0 = cyc;
		if (mem_req.re && mem_req.addr === 16'h0001) t_op1 = cyc;
		if (mem_req.we === 1'b1) writes++;
	end
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Each strobe lasts one cycle and is followed by a quiet cycle, so no edge sees two drives.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req <= '0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input bit chk, input string nm);
		note_q.push_back('{e, chk, nm});
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req <= '0;
		@(posedge core_clk);
	endtask
	// Start at a program counter and poll the busy bit under a bound; a hang fails the run.
	task automatic run_prog(input logic [15:0] pc);
		bit done;
		done = 1'b0;
		wr(`REG_STATUS, 8'h02);
		wr(`REG_PC_LO, pc[7:0]);
		wr(`REG_PC_HI, pc[15:8]);
		wr(`REG_CTRL, 8'h01);
		for (int i = 0; i < 200 && !done; i++) begin
			rd(`REG_STATUS, 8'h00, 1'b0, "");
			done = (status[`STATUS_BUSY_BIT] === 1'b0);
		end
		if (!done) begin
			fails++;
			finish_test();
		end
	endtask
	initial begin
		void'($urandom(32'h3c023106));
		reg_req = '0;
		arst_n = 1'b0;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(`REG_FLAGS, {3'h0, `FLAGS_RESET}, 1'b1, "flags reset");
		rd(`REG_SP, `SP_RESET, 1'b1, "sp reset");
		rd(4'hF, 8'h00, 1'b1, "unmapped");
		$display("test reset done");
		mem_u.mem[0] = `OP_PRODUCT;
		mem_u.mem[1] = 8'h20;
		// Largest operands first, then random pairs with every flag preset.
		for (int k = 0; k < 4; k++) begin
			a_v = (k == 0) ? 8'hFF : 8'($urandom);
			x_v = (k == 0) ? 8'hFF : 8'($urandom);
			prod = a_v * x_v;
			wr(`REG_ACC, a_v);
			wr(`REG_INDEX, x_v);
			wr(`REG_FLAGS, 8'h1F);
			run_prog(16'h0000);
			rd(`REG_ACC, prod[7:0], 1'b1, "product low");
			rd(`REG_INDEX, prod[15:8], 1'b1, "product high");
			rd(`REG_FLAGS, 8'h0E, 1'b1, "product flags");
			`CHK("product cycles", 11, t_op1 - t_op0)
		end
		$display("test product done");
		for (int i = 0; i < 24; i++) mem_u.mem[16'h0020 + i] = prog[i];
		mem_u.mem[16'h0080] = 8'h0A;
		mem_u.mem[16'h0190] = 8'h90;
		mem_u.mem[16'h0081] = 8'h7F;
		mem_u.mem[16'h0030] = 8'h21;
		wr(`REG_ACC, 8'h35);
		wr(`REG_INDEX, 8'h10);
		wr(`REG_FLAGS, 8'h09);
		writes = 0;
		run_prog(16'h0020);
		rd(`REG_ACC, 8'hF5, 1'b1, "alu acc");
		rd(`REG_INDEX, 8'h10, 1'b1, "index kept");
		rd(`REG_FLAGS, 8'h0A, 1'b1, "alu flags");
		rd(`REG_OPCODE, 8'h21, 1'b1, "jump target");
		`CHK("modified byte", 8'h80, mem_u.mem[16'h0081])
		`CHK("write count", 1, writes)
		$display("test alu done");
		// Stores, indexed loads, a call and an index increment, ending on a trap.
		for (int i = 0; i < 10; i++) mem_u.mem[16'h0040 + i] = prog2[i];
		mem_u.mem[16'h0060] = 8'h5C;
		mem_u.mem[16'h0061] = 8'h20;
		mem_u.mem[16'h0112] = 8'h6B;
		mem_u.mem[16'h0102] = 8'hC3;
		wr(`REG_INDEX, 8'h12);
		run_prog(16'h0040);
		`CHK("index store", 8'h12, mem_u.mem[16'h0090])
		`CHK("indexed store", 8'h6B, mem_u.mem[16'h0012])
		`CHK("return low", 8'h4A, mem_u.mem[16'h00FF])
		`CHK("return high", 8'h00, mem_u.mem[16'h00FE])
		rd(`REG_ACC, 8'hC3, 1'b1, "indexed load");
		rd(`REG_INDEX, 8'h13, 1'b1, "index increment");
		rd(`REG_SP, 8'hFD, 1'b1, "sp after call");
		rd(`REG_PC_LO, 8'h62, 1'b1, "pc after trap");
		rd(`REG_STATUS, 8'h02, 1'b1, "trap flag");
		$display("test call done");
		finish_test();
	end
endmodule
